// ==== rdp_pkg.sv ====
// constants, register map and types shared by the rmii data port files
package rdp_pkg;
  // timing of the generated reference clock at the 40 MHz system clock
  localparam int CLK_MHZ = 40;
  localparam int REF_HALF_NS = 10;
  localparam int REF_HALF_RAW = (REF_HALF_NS * CLK_MHZ) / 1000;
  localparam int REF_HALF_CYC = (REF_HALF_RAW < 1) ? 1 : REF_HALF_RAW;
  localparam logic [3:0] REF_DIV_LAST = 4'(REF_HALF_CYC - 1);
  // ten reference cycles carry one dibit at 10 Mbps
  localparam logic [3:0] SLOW_RATE_LAST = 4'h9;
  // carrier detect window at 100 Mbps, in received bits
  localparam int ZERO_WIN = 10;
  // mode strap codes
  localparam logic [2:0] STRAP_RMII = 3'h1;
  localparam logic [2:0] STRAP_B2B_RMII = 3'h5;
  localparam logic [2:0] STRAP_B2B_NIB = 3'h6;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // idle codes on the data pins
  localparam logic [1:0] DIBIT_IDLE = 2'h0;
  localparam logic [1:0] DIBIT_LPI = 2'h1;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXCNT = 8'h08;
  localparam logic [7:0] ADDR_RXERRCNT = 8'h0c;
  // control fields
  localparam int CTRL_CLK50 = 0;
  localparam int CTRL_SPEED100 = 1;
  localparam int CTRL_FDX = 2;
  localparam int CTRL_EEE = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h6;
  // status fields
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_RMII = 3;
  localparam int ST_REPEATER = 4;
  localparam int ST_CARRIER = 5;
  localparam int ST_CRSDV = 6;
  localparam int ST_TXEN = 7;
  localparam int ST_LPI = 8;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // width of the pin synchroniser bank
  localparam int SYNC_W = 9;
  // receive sequence
  typedef enum logic [2:0] {
    RDP_RX_IDLE = 3'h1,
    RDP_RX_WAIT = 3'h2,
    RDP_RX_DATA = 3'h4
  } rdp_rx_state_t;
endpackage

// ==== rdp_sync.sv ====
// two flip-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/1ps
module rdp_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // rdp_sync

// ==== rdp_data_port.sv ====
// rmii data port of the phy: reference clock, transmit and receive paths, axi registers
`timescale 1ns/1ps
// Overview of operation
// - transmit and receive each move one 2-bit dibit per reference cycle at 100 Mbps, per ten at 10 Mbps, independently
// - both 10 and 100 Mbps, half and full duplex, are supported
// - strap 001 with clock-mode bit 0 (reset value) selects 25 MHz mode
// - strap 001 with clock-mode bit 1 selects 50 MHz mode, clock on crystal input
// - 25 MHz mode drives the reference clock out; 50 MHz mode leaves it unused
// - the reference clock times txen, txd, rxd, rxer and the fall of crs_dv; crs_dv rises without it
// - while txen is high each sampled txd dibit goes to the line
// - crs_dv rises at once on carrier: squelch or two separate zeros in ten bits
// - crs_dv falls when carrier is lost
// - crs_dv covers first to last dibit and falls at the next dibit tick: next reference edge at 100 Mbps, up to ten at 10 Mbps
// - rxd reads 00 after crs_dv rises until data is decoded
// - each dibit tick with crs_dv high, once data is decoded, carries one recovered dibit
// - with crs_dv low rxd is 00, or 01 in low-power idle
// - a symbol error during crs_dv raises rxer for at least one reference cycle
// - strap 110 selects nibble back-to-back repeater at 100 Mbps on shared clock
// - nibble repeater cross-wires receive outputs to the peer's transmit inputs
// - strap 101 selects rmii repeater on shared clock, crs_dv/rxd feed peer
// - repeater operation runs at 100 Mbps only
module rdp_data_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] mode_strap,
  input wire logic crystal_input,
  output logic ref_clk,
  input wire logic txen,
  input wire logic [1:0] txd,
  input wire logic txer,
  output logic crs_dv,
  output logic [1:0] rxd,
  output logic rxer,
  input wire logic line_squelch_ok,
  input wire logic line_bit,
  input wire logic line_bit_stb,
  input wire logic line_eos,
  input wire logic [1:0] line_rx_dibit,
  input wire logic line_rx_stb,
  input wire logic line_sym_err,
  output logic [1:0] line_tx_dibit,
  output logic line_tx_stb,
  output logic line_tx_lpi,
  output logic line_speed100,
  output logic line_full_duplex
);
  logic [rdp_pkg::SYNC_W-1:0] sync_q;
  logic [1:0] txd_s;
  logic txen_s, txer_s, xi_s, squelch_s;
  logic [2:0] strap_s, strap_q;
  logic [1:0] strap_wait_q;
  logic strap_done_q, rmii_ok_q, repeater_q;
  logic [rdp_pkg::CTRL_W-1:0] ctrl_q;
  logic clk50, speed100, eee;
  logic [3:0] ref_div_q, rate_q;
  logic ref_out_q, xi_prev_q, gen_tick, ext_tick, ref_tick, data_tick;
  logic [rdp_pkg::ZERO_WIN-1:0] zero_win_q;
  logic [rdp_pkg::ZERO_WIN-3:0] pair_vec;
  logic carrier_q, carrier_det, carrier_lost;
  rdp_pkg::rdp_rx_state_t rx_state_q;
  logic [1:0] rx_hold_q, rxd_q;
  logic crs_dv_q, rxer_q, err_pend_q;
  logic [1:0] tx_dibit_q;
  logic tx_stb_q, tx_lpi_q;
  logic [31:0] tx_cnt_q, rxerr_cnt_q;
  logic awfull_q, wfull_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_mux;
  logic wstrb0_q, wr_exec, rd_hit;
  logic [1:0] bresp_q, rresp_q;

  // pins from the mac and the line analog front end
  rdp_sync #(.W(rdp_pkg::SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({mode_strap, line_squelch_ok, crystal_input, txer, txen, txd}),
    .q(sync_q)
  );
  assign txd_s = sync_q[1:0];
  assign txen_s = sync_q[2];
  assign txer_s = sync_q[3];
  assign xi_s = sync_q[4];
  assign squelch_s = sync_q[5];
  assign strap_s = sync_q[8:6];

  // strap capture once the synchroniser has settled after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q <= 3'h0;
      rmii_ok_q <= 1'b0;
      repeater_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      if (strap_wait_q == rdp_pkg::STRAP_SETTLE)
      begin
        strap_done_q <= 1'b1;
        strap_q <= strap_s;
        rmii_ok_q <= (strap_s == rdp_pkg::STRAP_RMII) || (strap_s == rdp_pkg::STRAP_B2B_RMII)
          || (strap_s == rdp_pkg::STRAP_B2B_NIB);
        repeater_q <= (strap_s == rdp_pkg::STRAP_B2B_RMII) || (strap_s == rdp_pkg::STRAP_B2B_NIB);
      end
      else
      begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // repeater runs from the shared clock at 100 Mbps only
  assign clk50 = ctrl_q[rdp_pkg::CTRL_CLK50] | repeater_q;
  assign speed100 = ctrl_q[rdp_pkg::CTRL_SPEED100] | repeater_q;
  assign eee = ctrl_q[rdp_pkg::CTRL_EEE];

  // reference clock divider, driven out only in 25 MHz mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_div_q <= 4'h0;
      ref_out_q <= 1'b0;
    end
    else if (clk50)
    begin
      ref_div_q <= 4'h0;
      ref_out_q <= 1'b0;
    end
    else if (ref_div_q == rdp_pkg::REF_DIV_LAST)
    begin
      ref_div_q <= 4'h0;
      ref_out_q <= ~ref_out_q;
    end
    else
    begin
      ref_div_q <= ref_div_q + 4'h1;
    end
  end

  // rising edge of the external reference on the crystal input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xi_prev_q <= 1'b0;
    else
      xi_prev_q <= xi_s;
  end
  assign gen_tick = !clk50 && (ref_div_q == rdp_pkg::REF_DIV_LAST) && !ref_out_q;
  assign ext_tick = clk50 && xi_s && !xi_prev_q;
  assign ref_tick = (gen_tick | ext_tick) & strap_done_q & rmii_ok_q;

  // dibit pacing: every reference edge at 100 Mbps, every tenth at 10 Mbps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rate_q <= 4'h0;
    else if (ref_tick)
      rate_q <= (speed100 || rate_q == rdp_pkg::SLOW_RATE_LAST) ? 4'h0 : rate_q + 4'h1;
  end
  assign data_tick = ref_tick && (speed100 || rate_q == rdp_pkg::SLOW_RATE_LAST);

  // transmit path toward the line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_dibit_q <= rdp_pkg::DIBIT_IDLE;
      tx_stb_q <= 1'b0;
      tx_lpi_q <= 1'b0;
    end
    else
    begin
      tx_stb_q <= data_tick && txen_s;
      if (data_tick)
      begin
        tx_dibit_q <= txen_s ? txd_s : rdp_pkg::DIBIT_IDLE;
        tx_lpi_q <= eee && !txen_s && (txer_s || txd_s == rdp_pkg::DIBIT_LPI);
      end
    end
  end

  // zero flags of the last ten received bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn || line_eos)
      zero_win_q <= '0;
    else if (line_bit_stb)
      zero_win_q <= {zero_win_q[rdp_pkg::ZERO_WIN-2:0], ~line_bit};
  end

  // two zeros at least one bit apart
  for (genvar g = 0; g < rdp_pkg::ZERO_WIN - 2; g++)
  begin : g_pair
    assign pair_vec[g] = zero_win_q[g] & (|zero_win_q[rdp_pkg::ZERO_WIN-1:g+2]);
  end
  assign carrier_det = speed100 ? (|pair_vec) : squelch_s;
  assign carrier_lost = speed100 ? line_eos : !squelch_s;

  // carrier state
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !strap_done_q)
      carrier_q <= 1'b0;
    else if (!carrier_q && carrier_det)
      carrier_q <= 1'b1;
    else if (carrier_q && carrier_lost)
      carrier_q <= 1'b0;
  end

  // latest decoded dibit and symbol error from the line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_hold_q <= rdp_pkg::DIBIT_IDLE;
      err_pend_q <= 1'b0;
    end
    else
    begin
      if (line_rx_stb)
        rx_hold_q <= line_rx_dibit;
      if (line_sym_err && carrier_q)
        err_pend_q <= 1'b1;
      else if (data_tick || !carrier_q)
        err_pend_q <= 1'b0;
    end
  end

  // receive sequence: idle, carrier seen but undecoded, data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_state_q <= rdp_pkg::RDP_RX_IDLE;
    else
      case (rx_state_q)
        rdp_pkg::RDP_RX_IDLE:
          if (carrier_q)
            rx_state_q <= rdp_pkg::RDP_RX_WAIT;
        rdp_pkg::RDP_RX_WAIT:
          if (data_tick && !carrier_q)
            rx_state_q <= rdp_pkg::RDP_RX_IDLE;
          else if (line_rx_stb)
            rx_state_q <= rdp_pkg::RDP_RX_DATA;
        rdp_pkg::RDP_RX_DATA:
          if (data_tick && !carrier_q)
            rx_state_q <= rdp_pkg::RDP_RX_IDLE;
        default:
          rx_state_q <= rdp_pkg::RDP_RX_IDLE;
      endcase
  end

  // crs_dv: raised without waiting for a reference edge, dropped on one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      crs_dv_q <= 1'b0;
    else if (carrier_q)
      crs_dv_q <= 1'b1;
    else if (data_tick)
      crs_dv_q <= 1'b0;
  end

  // receive data and error toward the mac, following the crs_dv level of this tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rxd_q <= rdp_pkg::DIBIT_IDLE;
      rxer_q <= 1'b0;
    end
    else if (data_tick)
    begin
      if (carrier_q && rx_state_q == rdp_pkg::RDP_RX_DATA)
        rxd_q <= rx_hold_q;
      else if (carrier_q)
        rxd_q <= rdp_pkg::DIBIT_IDLE;
      else
        rxd_q <= eee ? rdp_pkg::DIBIT_LPI : rdp_pkg::DIBIT_IDLE;
      rxer_q <= carrier_q && err_pend_q;
    end
  end

  // activity counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_cnt_q <= 32'h0000_0000;
      rxerr_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      if (tx_stb_q)
        tx_cnt_q <= tx_cnt_q + 32'h0000_0001;
      if (data_tick && carrier_q && err_pend_q)
        rxerr_cnt_q <= rxerr_cnt_q + 32'h0000_0001;
    end
  end

  // axi write address and data capture, response after both
  assign wr_exec = awfull_q && wfull_q && !bvalid_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awfull_q <= 1'b0;
      wfull_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= rdp_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awfull_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wfull_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_exec)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == rdp_pkg::ADDR_CTRL) ? rdp_pkg::RESP_OKAY : rdp_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awfull_q <= 1'b0;
        wfull_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= rdp_pkg::CTRL_RESET;
    else if (wr_exec && wstrb0_q && awaddr_q == rdp_pkg::ADDR_CTRL)
      ctrl_q <= wdata_q[rdp_pkg::CTRL_W-1:0];
  end

  // read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      rdp_pkg::ADDR_CTRL: rd_mux[rdp_pkg::CTRL_W-1:0] = ctrl_q;
      rdp_pkg::ADDR_STATUS:
      begin
        rd_mux[rdp_pkg::ST_STRAP_LSB +: 3] = strap_q;
        rd_mux[rdp_pkg::ST_RMII] = rmii_ok_q;
        rd_mux[rdp_pkg::ST_REPEATER] = repeater_q;
        rd_mux[rdp_pkg::ST_CARRIER] = carrier_q;
        rd_mux[rdp_pkg::ST_CRSDV] = crs_dv_q;
        rd_mux[rdp_pkg::ST_TXEN] = txen_s;
        rd_mux[rdp_pkg::ST_LPI] = tx_lpi_q;
      end
      rdp_pkg::ADDR_TXCNT: rd_mux = tx_cnt_q;
      rdp_pkg::ADDR_RXERRCNT: rd_mux = rxerr_cnt_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // axi read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= rdp_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? rdp_pkg::RESP_OKAY : rdp_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // line side mode outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_speed100 <= 1'b0;
      line_full_duplex <= 1'b0;
    end
    else
    begin
      line_speed100 <= speed100;
      line_full_duplex <= ctrl_q[rdp_pkg::CTRL_FDX] & ~repeater_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign ref_clk = ref_out_q;
  assign crs_dv = crs_dv_q;
  assign rxd = rxd_q;
  assign rxer = rxer_q;
  assign line_tx_dibit = tx_dibit_q;
  assign line_tx_stb = tx_stb_q;
  assign line_tx_lpi = tx_lpi_q;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_rxd_idle;
    (data_tick && !carrier_q) |=> (rxd_q == (eee ? rdp_pkg::DIBIT_LPI : rdp_pkg::DIBIT_IDLE));
  endproperty
  a_rxd_idle: assert property (p_rxd_idle) else $error("rxd idle code wrong");

  property p_rxd_undecoded;
    (data_tick && carrier_q && rx_state_q != rdp_pkg::RDP_RX_DATA) |=> (rxd_q == rdp_pkg::DIBIT_IDLE);
  endproperty
  a_rxd_undecoded: assert property (p_rxd_undecoded) else $error("rxd not 00 before decode");

  property p_rxd_data;
    (data_tick && carrier_q && rx_state_q == rdp_pkg::RDP_RX_DATA) |=> (rxd_q == $past(rx_hold_q));
  endproperty
  a_rxd_data: assert property (p_rxd_data) else $error("rxd missed recovered dibit");

  property p_crs_rise;
    $rose(carrier_q) |=> crs_dv_q;
  endproperty
  a_crs_rise: assert property (p_crs_rise) else $error("crs_dv late on carrier");

  property p_crs_fall;
    (data_tick && !carrier_q) |=> !crs_dv_q;
  endproperty
  a_crs_fall: assert property (p_crs_fall) else $error("crs_dv held after carrier loss");

  property p_tx_accept;
    (data_tick && txen_s) |=> (line_tx_stb && line_tx_dibit == $past(txd_s));
  endproperty
  a_tx_accept: assert property (p_tx_accept) else $error("txd dibit not passed on");

  property p_rxer;
    (data_tick && carrier_q && err_pend_q) |=> rxer_q;
  endproperty
  a_rxer: assert property (p_rxer) else $error("rxer missing on symbol error");

  property p_ref_quiet;
    clk50 ##1 clk50 |-> !ref_out_q;
  endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("ref clock driven in 50 MHz mode");

  property p_ref_toggle;
    (!clk50 && ref_div_q == rdp_pkg::REF_DIV_LAST) ##1 !clk50 |-> (ref_out_q != $past(ref_out_q));
  endproperty
  a_ref_toggle: assert property (p_ref_toggle) else $error("ref clock not generated");

  property p_repeater_speed;
    repeater_q |=> (line_speed100 && !line_full_duplex);
  endproperty
  a_repeater_speed: assert property (p_repeater_speed) else $error("repeater not at 100 Mbps");

  property p_strap_hold;
    strap_done_q |=> $stable(strap_q) && strap_done_q;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");
endmodule // rdp_data_port

// ==== rdp_mac_model.sv ====
// mac model on the transmit side: one short frame per request, idle codes between
`timescale 1ns/1ps
module rdp_mac_model (
  input wire logic ref_in,
  input wire logic send,
  input wire logic [7:0] frame,
  input wire logic eee,
  input wire logic crs_dv,
  output logic txen = 1'b0,
  output logic [1:0] txd = 2'h0,
  output logic txer = 1'b0,
  output logic col
);
  int idx = 0;
  logic done_q = 1'b0;
  // collision built from own transmit and the carrier
  assign col = txen & crs_dv;
  // change on the falling edge so pins are steady at the rising one
  always @(negedge ref_in)
  begin
    if (send && !done_q && idx < 4)
    begin
      txen <= 1'b1;
      txer <= 1'b0;
      txd <= frame[2*idx +: 2];
      idx <= idx + 1;
    end
    else
    begin
      txen <= 1'b0;
      txer <= eee;
      txd <= eee ? 2'h1 : 2'h0;
      idx <= 0;
      done_q <= send;
    end
  end
endmodule // rdp_mac_model

// ==== tb.sv ====
// testbench for the rmii data port with the mac model on its transmit pins
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] resp;} rdp_row_t;
  logic aclk = 0, aresetn = 0, crystal_input = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, txd, rxd, line_tx_dibit;
  logic [2:0] mode_strap = 3'h1;
  logic ref_clk, txen, txer, crs_dv, rxer, col, line_tx_stb, line_tx_lpi, line_speed100, line_full_duplex;
  logic line_squelch_ok = 0, line_bit = 0, line_bit_stb = 0, line_eos = 0, line_rx_stb = 0, line_sym_err = 0;
  logic [1:0] line_rx_dibit = 0;
  logic mac_send = 0, mac_eee = 0;
  logic [1:0] got[$];
  int n_fail = 0, checks = 0, cyc = 0, tog;
  rdp_row_t rows [8];

  rdp_data_port i_rdp_data_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mode_strap, .crystal_input, .ref_clk, .txen, .txd, .txer, .crs_dv, .rxd, .rxer, .line_squelch_ok,
    .line_bit, .line_bit_stb, .line_eos, .line_rx_dibit, .line_rx_stb, .line_sym_err, .line_tx_dibit,
    .line_tx_stb, .line_tx_lpi, .line_speed100, .line_full_duplex);
  rdp_mac_model i_rdp_mac_model (.ref_in(crystal_input), .send(mac_send), .frame(8'h1e), .eee(mac_eee),
    .crs_dv, .txen, .txd, .txer, .col);

  // system clock and free running external reference
  always #12.5 aclk = ~aclk;
  always #100 crystal_input = ~crystal_input;
  // collect every dibit handed to the line
  always @(posedge aclk)
    if (line_tx_stb) got.push_back(line_tx_dibit);
  // hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      test_done();
    end
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // axi write: address and data offered together, bready held till bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // axi read, rready held till rvalid
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // count high samples of ref_clk over eight cycles
  task automatic ref_watch;
    tog = 0;
    repeat (8)
    begin
      @(posedge aclk);
      tog += ref_clk;
    end
  endtask
  // one pulse on a line strobe
  task automatic pulse(ref logic s);
    @(posedge aclk);
    s <= 1;
    @(posedge aclk);
    s <= 0;
  endtask

  initial
  begin
    // register cases: write flag, address, data or expected read, response
    rows = '{'{0, 8'h00, 32'h6, 2'h0}, '{0, 8'h04, 32'h9, 2'h0}, '{0, 8'h10, 32'h0, 2'h2},
      '{1, 8'h04, 32'h1, 2'h2}, '{1, 8'h10, 32'h0, 2'h2}, '{0, 8'h0c, 32'h0, 2'h0},
      '{1, 8'h00, 32'h7, 2'h0}, '{0, 8'h00, 32'h7, 2'h0}};
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    chk("reset outputs", {crs_dv, rxd, rxer, line_tx_stb, ref_clk}, 0);
    repeat (8) @(posedge aclk);
    ref_watch();
    chk("ref_clk driven", tog > 0 && tog < 8, 1);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_wr(rows[i].a, rows[i].d);
      else
        axi_rd(rows[i].a);
      chk("resp", rsp, rows[i].resp);
      if (!rows[i].wr)
        chk("rdata", rd_d, rows[i].d);
    end
    ref_watch();
    chk("ref_clk unused", tog, 0);
    chk("speed duplex", {line_speed100, line_full_duplex}, 2'h3);
    // transmit one frame of four dibits
    @(posedge aclk);
    mac_send <= 1;
    repeat (60) @(posedge aclk);
    mac_send <= 0;
    chk("tx dibits", got.size(), 4);
    for (int i = 0; i < 4; i++)
      chk("tx dibit", got[i], (8'h1e >> (2 * i)) & 8'h3);
    axi_rd(8'h08);
    chk("tx count", rd_d, 4);
    // receive: zeros at bits 0 and 2 of the window
    @(posedge aclk);
    line_bit_stb <= 1;
    @(posedge aclk);
    line_bit <= 1;
    @(posedge aclk);
    line_bit <= 0;
    @(posedge aclk);
    line_bit_stb <= 0;
    repeat (4) @(posedge aclk);
    chk("carrier", crs_dv, 1);
    repeat (10) @(posedge aclk);
    chk("rxd undecoded", rxd, 0);
    line_rx_dibit <= 2'h2;
    pulse(line_rx_stb);
    repeat (12) @(posedge aclk);
    chk("rxd data", {crs_dv, rxd}, 3'h6);
    pulse(line_sym_err);
    tog = 0;
    repeat (20)
    begin
      @(posedge aclk);
      tog |= rxer;
    end
    chk("rxer", tog, 1);
    pulse(line_eos);
    repeat (12) @(posedge aclk);
    chk("carrier lost", {crs_dv, rxd}, 0);
    // low-power idle on the transmit side
    axi_wr(8'h00, 32'hf);
    mac_eee <= 1;
    repeat (20) @(posedge aclk);
    chk("tx lpi", {line_tx_lpi, 3'(got.size())}, 4'hc);
    // repeater strap, changed after capture
    aresetn <= 0;
    mode_strap <= 3'h5;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    repeat (8) @(posedge aclk);
    mode_strap <= 3'h1;
    repeat (8) @(posedge aclk);
    chk("repeater mode", {line_speed100, line_full_duplex, ref_clk}, 3'h4);
    axi_rd(8'h04);
    chk("strap held", rd_d[4:0], 5'h1d);
    test_done();
  end
endmodule // tb
